// File: spp_pad_model.sv
// Board side of the pads: driven pins loop back, others follow the board
`timescale 1ns/1ps
module spp_pad_model #(
   parameter int WIDTH = 16 // Pins modelled
)
(
   input  wire logic [WIDTH-1:0] pin_out,   // Pad output data
   input  wire logic [WIDTH-1:0] pin_oe,    // Pad output enables
   input  wire logic [WIDTH-1:0] ext_level, // Board level when undriven
   output logic      [WIDTH-1:0] pin_in     // Level seen on the pads
);
   // Released pads show the board driver, never the last port value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// File: spp_pin_cell.sv
// One pin bit: ownership multiplexers, drive enable and input qualification
`timescale 1ns/1ps
module spp_pin_cell
   import spp_pkg::*;
(
   input  wire logic aclk,         // System clock
   input  wire logic aresetn,      // Synchronous reset, active low
   input  wire logic present,      // Bit exists on this device
   input  wire logic dir_in,       // Direction bit, 1 is input
   input  wire logic latch,        // Output latch value
   input  wire logic od_sel,       // Open-drain select
   input  wire logic analog,       // Pin in analog mode
   input  wire logic peri_en,      // Sharing peripheral enabled
   input  wire logic peri_oe,      // Peripheral actively driving
   input  wire logic peri_out,     // Peripheral output data
   input  wire logic pin_in,       // Raw pin level
   output logic      pin_out,      // Pin output data
   output logic      pin_oe,       // Pin output enable
   output logic      peri_in,      // Level presented to peripheral
   output logic      level         // Synchronised level for reads
);
   logic sync1;
   logic sync2;
   logic peri_owns;
   logic port_data;
   logic port_oe;
   logic next_out;
   logic next_oe;

   // Peripheral takes the pin only while enabled and driving
   assign peri_owns = present & peri_en & peri_oe;
   // Open-drain drives only a low, floats a high
   assign port_data = od_sel ? 1'b0 : latch;
   assign port_oe   = present & ~dir_in & ~(od_sel & latch);
   // Output multiplexer pair
   assign next_out  = peri_owns ? peri_out : port_data;
   assign next_oe   = peri_owns ? 1'b1 : port_oe;

   // Registered pad drive; reset leaves the pin an input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe  <= next_oe;
      end
   end

   // Two-stage synchroniser on the pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   // Read level and peripheral input; port drive is masked from peri_in, not from level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level   <= 1'b0;
         peri_in <= 1'b0;
      end else begin
         level   <= present & ~analog & sync2;
         peri_in <= (peri_owns | ~port_oe) & sync2;
      end
   end
endmodule

// File: spp_pkg.sv
// Package with register map, field constants and states for the shared pin port
package spp_pkg;
   // Register byte addresses
   localparam logic [7:0] SPP_ADDR_DIR      = 8'h00;
   localparam logic [7:0] SPP_ADDR_LATCH    = 8'h04;
   localparam logic [7:0] SPP_ADDR_LEVEL    = 8'h08;
   localparam logic [7:0] SPP_ADDR_ODSEL    = 8'h0c;
   localparam logic [7:0] SPP_ADDR_PERI_EN  = 8'h10;
   localparam logic [7:0] SPP_ADDR_ANALOG   = 8'h14;
   localparam logic [7:0] SPP_ADDR_IN_ONLY  = 8'h18;
   // Address field width used for decoding
   localparam int         SPP_AW            = 8;
   // Word alignment bits
   localparam int         SPP_ALIGN_BITS    = 2;
   // AXI response codes
   localparam logic [1:0] SPP_RESP_OKAY     = 2'h0;
   localparam logic [1:0] SPP_RESP_SLVERR   = 2'h2;
   // Reset values
   localparam logic [31:0] SPP_DIR_RST      = 32'hffffffff;
   localparam logic [31:0] SPP_ZERO         = 32'h00000000;
   // Write channel states, one-hot
   typedef enum logic [2:0] {
      SPP_W_IDLE = 3'b001,
      SPP_W_WAIT = 3'b010,
      SPP_W_RESP = 3'b100
   } spp_wstate_e;
endpackage

// File: spp_port.sv
// Shared pin parallel port with AXI4-Lite register slave
`timescale 1ns/1ps
module spp_port
   import spp_pkg::*;
#(
   parameter int          WIDTH   = 16,          // Pins in the port
   parameter logic [31:0] PRESENT = 32'h0000ffff // Implemented bit mask
)
(
   input  wire logic             aclk,          // System clock
   input  wire logic             aresetn,       // Synchronous reset, low
   input  wire logic [7:0]       s_axi_awaddr,  // Write address
   input  wire logic             s_axi_awvalid, // Write address valid
   output logic                  s_axi_awready, // Write address ready
   input  wire logic [31:0]      s_axi_wdata,   // Write data
   input  wire logic [3:0]       s_axi_wstrb,   // Write byte strobes
   input  wire logic             s_axi_wvalid,  // Write data valid
   output logic                  s_axi_wready,  // Write data ready
   output logic [1:0]            s_axi_bresp,   // Write response
   output logic                  s_axi_bvalid,  // Write response valid
   input  wire logic             s_axi_bready,  // Write response ready
   input  wire logic [7:0]       s_axi_araddr,  // Read address
   input  wire logic             s_axi_arvalid, // Read address valid
   output logic                  s_axi_arready, // Read address ready
   output logic [31:0]           s_axi_rdata,   // Read data
   output logic [1:0]            s_axi_rresp,   // Read response
   output logic                  s_axi_rvalid,  // Read data valid
   input  wire logic             s_axi_rready,  // Read data ready
   input  wire logic [WIDTH-1:0] peri_oe,       // Peripheral drive enables
   input  wire logic [WIDTH-1:0] peri_out,      // Peripheral output data
   output logic      [WIDTH-1:0] peri_in,       // Peripheral input levels
   input  wire logic [WIDTH-1:0] pin_in,        // Pad input levels
   output logic      [WIDTH-1:0] pin_out,       // Pad output data
   output logic      [WIDTH-1:0] pin_oe         // Pad output enables
);
   // Width check
   if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("spp_port: WIDTH must be 1 to 32");
   end

   localparam logic [WIDTH-1:0] MASK = PRESENT[WIDTH-1:0];

   logic [WIDTH-1:0]  pin_direction_reg;
   logic [WIDTH-1:0]  output_latch_reg;
   logic [WIDTH-1:0]  open_drain_select_reg;
   logic [WIDTH-1:0]  peri_enable_reg;
   logic [WIDTH-1:0]  analog_sel_reg;
   logic [WIDTH-1:0]  input_only_reg;
   logic [WIDTH-1:0]  pin_level_reg;
   spp_wstate_e       wstate;
   logic              aw_held;
   logic              w_held;
   logic [SPP_AW-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_write;
   logic [SPP_AW-1:0] wa;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic              w_known;
   logic [31:0]       strb_mask;
   logic [WIDTH-1:0]  eff_peri_en;

   // Byte strobes widened to a bit mask
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         strb_mask[b*8 +: 8] = {8{w_strb[b]}};
      end
   end

   // Write commit when both address and data are held
   assign do_write = (wstate == SPP_W_WAIT) & aw_held & w_held;
   assign wa       = aw_addr;

   // Address decoding for writes
   always_comb begin
      if (wa == SPP_ADDR_DIR)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_LATCH)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_LEVEL)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_ODSEL)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_PERI_EN)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_ANALOG)
         w_known = 1'b1;
      else if (wa == SPP_ADDR_IN_ONLY)
         w_known = 1'b1;
      else
         w_known = 1'b0;
   end

   // Write channel: accept address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate        <= SPP_W_IDLE;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= SPP_ZERO;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= SPP_RESP_OKAY;
      end else begin
         case (wstate)
            SPP_W_IDLE: begin
               s_axi_awready <= 1'b1;
               s_axi_wready  <= 1'b1;
               wstate        <= SPP_W_WAIT;
            end
            SPP_W_WAIT: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_held       <= 1'b1;
                  aw_addr       <= {s_axi_awaddr[SPP_AW-1:SPP_ALIGN_BITS],
                                    {SPP_ALIGN_BITS{1'b0}}};
                  s_axi_awready <= 1'b0;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_held       <= 1'b1;
                  w_data       <= s_axi_wdata;
                  w_strb       <= s_axi_wstrb;
                  s_axi_wready <= 1'b0;
               end
               if (do_write) begin
                  aw_held      <= 1'b0;
                  w_held       <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= w_known ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
                  wstate       <= SPP_W_RESP;
               end
            end
            SPP_W_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid  <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wstate        <= SPP_W_WAIT;
               end
            end
            default: begin
               wstate <= SPP_W_IDLE;
            end
         endcase
      end
   end

   // Direction register; all inputs after reset
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pin_direction_reg <= SPP_DIR_RST[WIDTH-1:0];
      else if (do_write && wa == SPP_ADDR_DIR)
         pin_direction_reg <= (pin_direction_reg & ~strb_mask[WIDTH-1:0])
                            | (w_data[WIDTH-1:0] & strb_mask[WIDTH-1:0]);
   end

   // Output latch, written through either latch or level address
   always_ff @(posedge aclk) begin
      if (!aresetn)
         output_latch_reg <= SPP_ZERO[WIDTH-1:0];
      else if (do_write && (wa == SPP_ADDR_LATCH || wa == SPP_ADDR_LEVEL))
         output_latch_reg <= (output_latch_reg & ~strb_mask[WIDTH-1:0])
                           | (w_data[WIDTH-1:0] & strb_mask[WIDTH-1:0]);
   end

   // Open-drain, peripheral enable, analog and input-only selects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_drain_select_reg <= SPP_ZERO[WIDTH-1:0];
         peri_enable_reg       <= SPP_ZERO[WIDTH-1:0];
         analog_sel_reg        <= SPP_ZERO[WIDTH-1:0];
         input_only_reg        <= SPP_ZERO[WIDTH-1:0];
      end else if (do_write) begin
         if (wa == SPP_ADDR_ODSEL)
            open_drain_select_reg <= w_data[WIDTH-1:0];
         else if (wa == SPP_ADDR_PERI_EN)
            peri_enable_reg <= w_data[WIDTH-1:0];
         else if (wa == SPP_ADDR_ANALOG)
            analog_sel_reg <= w_data[WIDTH-1:0];
         else if (wa == SPP_ADDR_IN_ONLY)
            input_only_reg <= w_data[WIDTH-1:0];
      end
   end

   // Input-only functions never compete for the output path
   assign eff_peri_en = peri_enable_reg & ~input_only_reg;

   // Per-pin cells
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      spp_pin_cell u_cell (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .present  (MASK[i]),
         .dir_in   (pin_direction_reg[i]),
         .latch    (output_latch_reg[i]),
         .od_sel   (open_drain_select_reg[i]),
         .analog   (analog_sel_reg[i]),
         .peri_en  (eff_peri_en[i]),
         .peri_oe  (peri_oe[i]),
         .peri_out (peri_out[i]),
         .pin_in   (pin_in[i]),
         .pin_out  (pin_out[i]),
         .pin_oe   (pin_oe[i]),
         .peri_in  (peri_in[i]),
         .level    (pin_level_reg[i])
      );
   end

   // Read data mux; upper bits read zero, missing bits read zero only in direction, latch and level
   always_comb begin
      next_rdata = SPP_ZERO;
      next_rresp = SPP_RESP_OKAY;
      if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
          SPP_ADDR_DIR[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = pin_direction_reg & MASK;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_LATCH[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = output_latch_reg & MASK;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_LEVEL[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = pin_level_reg;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_ODSEL[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = open_drain_select_reg;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_PERI_EN[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = peri_enable_reg;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_ANALOG[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = analog_sel_reg;
      else if (s_axi_araddr[SPP_AW-1:SPP_ALIGN_BITS] ==
               SPP_ADDR_IN_ONLY[SPP_AW-1:SPP_ALIGN_BITS])
         next_rdata[WIDTH-1:0] = input_only_reg;
      else
         next_rresp = SPP_RESP_SLVERR;
   end

   // Read channel: one read at a time, data one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= SPP_ZERO;
         s_axi_rresp   <= SPP_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// File: spp_port_assertions.sv
// Concurrent checks on the shared pin port top-level ports
`timescale 1ns/1ps
module spp_port_assertions
   import spp_pkg::*;
#(
   parameter int          WIDTH   = 16,          // Pins in the port
   parameter logic [31:0] PRESENT = 32'h0000ffff // Implemented bit mask
)
(
   input wire logic             aclk,          // System clock
   input wire logic             aresetn,       // Synchronous reset, low
   input wire logic             s_axi_awvalid, // Write address valid
   input wire logic             s_axi_awready, // Write address ready
   input wire logic             s_axi_wvalid,  // Write data valid
   input wire logic             s_axi_wready,  // Write data ready
   input wire logic [1:0]       s_axi_bresp,   // Write response
   input wire logic             s_axi_bvalid,  // Write response valid
   input wire logic             s_axi_bready,  // Write response ready
   input wire logic             s_axi_arvalid, // Read address valid
   input wire logic             s_axi_arready, // Read address ready
   input wire logic [31:0]      s_axi_rdata,   // Read data
   input wire logic             s_axi_rvalid,  // Read data valid
   input wire logic             s_axi_rready,  // Read data ready
   input wire logic [WIDTH-1:0] peri_oe,       // Peripheral drive enables
   input wire logic [WIDTH-1:0] peri_in,       // Peripheral input levels
   input wire logic [WIDTH-1:0] pin_in,        // Pad input levels
   input wire logic [WIDTH-1:0] pin_oe         // Pad output enables
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshake and pin-state sequences
   sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
   sequence s_w_take; s_axi_wvalid && s_axi_wready; endsequence
   sequence s_port_drives; (pin_oe[1] && !peri_oe[1]) [*4]; endsequence
   sequence s_quiet_in; (!pin_oe[0] && $stable(pin_in[0])) [*4]; endsequence
   // Pin-side properties
   property p_reset_inputs;
      $rose(aresetn) |-> pin_oe == '0 && peri_in == '0;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("pins driven right after reset");
   property p_absent_idle;
      (pin_oe & ~PRESENT[WIDTH-1:0]) == '0;
   endproperty
   a_absent_idle: assert property (p_absent_idle)
      else $error("absent bit driven");
   property p_sync_level;
      s_quiet_in |-> peri_in[0] == pin_in[0];
   endproperty
   a_sync_level: assert property (p_sync_level)
      else $error("settled pad level not passed through");
   property p_no_loop;
      s_port_drives |-> !peri_in[1];
   endproperty
   a_no_loop: assert property (p_no_loop)
      else $error("port output looped into peripheral");
   // Register bus properties
   property p_write_resp;
      (s_aw_take and s_w_take) |=> ##1 s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp)
      else $error("write response late");
   property p_resp_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_resp_hold: assert property (p_resp_hold)
      else $error("write response dropped");
   property p_read_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_read_resp: assert property (p_read_resp)
      else $error("read data late");
   property p_read_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read data dropped");
endmodule

// File: spp_port_bench.sv
// Self-checking testbench for the shared pin port
`timescale 1ns/1ps
module spp_port_bench
   import spp_pkg::*;
;
   localparam int          W    = 16;
   localparam logic [31:0] PRES = 32'h00007fff;
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]  s_axi_wdata = 32'h0;
   logic [3:0]   s_axi_wstrb = 4'hf;
   logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic         s_axi_rready = 1'b0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic         s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic [31:0]  s_axi_rdata;
   logic [W-1:0] peri_oe = '0, peri_out = '0, ext_level = 16'ha5b1;
   logic [W-1:0] peri_in, pin_in, pin_out, pin_oe;
   int           err_count = 0, checks_done = 0;

   spp_port #(.WIDTH(W), .PRESENT(PRES)) i_spp_port (.*);
   spp_pad_model #(.WIDTH(W)) i_spp_pad_model (.pin_out, .pin_oe,
      .ext_level, .pin_in);

   // Clock at 25 MHz
   always #20 aclk = ~aclk;

   // Compare a seen value with the expected one
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hold reset for five cycles
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // One write, address and data offered together; lag holds off bready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er, input int lag = 0,
                         input logic [3:0] st = 4'hf);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      if (lag > 0) begin
         repeat (lag - 1) @(posedge aclk);
         s_axi_bready <= 1'b1;
         @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk); // Gap before the next port access
   endtask

   // One read with expected data and response; lag holds off rready
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er, input string nm,
                         input int lag = 0);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      if (lag > 0) begin
         repeat (lag - 1) @(posedge aclk);
         s_axi_rready <= 1'b1;
         @(posedge aclk);
      end
      s_axi_rready <= 1'b0;
      chk(nm, s_axi_rdata, ed);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk); // Gap before the next port access
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      do_reset();
      chk("pin_oe", {16'h0, pin_oe}, 32'h0);
      axi_rd(SPP_ADDR_DIR, PRES, SPP_RESP_OKAY, "dir");
      axi_rd(SPP_ADDR_LATCH, 32'h0, SPP_RESP_OKAY, "latch");
      axi_wr(SPP_ADDR_DIR, 32'h0000fff1, SPP_RESP_OKAY);
      axi_wr(SPP_ADDR_LATCH, 32'hffffffff, SPP_RESP_OKAY);
      axi_rd(SPP_ADDR_LATCH, PRES, SPP_RESP_OKAY, "latch");
      axi_wr(SPP_ADDR_LATCH, 32'h0, SPP_RESP_OKAY, 2, 4'h2);
      axi_rd(SPP_ADDR_LATCH, 32'h00ff, SPP_RESP_OKAY, "latch", 2);
      chk("pin_oe", {16'h0, pin_oe}, 32'h0000000e);
      chk("pin_out", {16'h0, pin_out & 16'h000e}, 32'he);
      repeat (4) @(posedge aclk);
      chk("peri_in", {16'h0, peri_in & 16'h0003}, 32'h1);
      axi_wr(SPP_ADDR_LEVEL, 32'h0, SPP_RESP_OKAY);
      axi_rd(SPP_ADDR_LATCH, 32'h0, SPP_RESP_OKAY, "latch");
      repeat (4) @(posedge aclk);
      axi_rd(SPP_ADDR_LEVEL, 32'h25b1, SPP_RESP_OKAY, "level");
      axi_wr(SPP_ADDR_ANALOG, 32'h10, SPP_RESP_OKAY);
      repeat (4) @(posedge aclk);
      axi_rd(SPP_ADDR_LEVEL, 32'h25a1, SPP_RESP_OKAY, "level");
      axi_wr(SPP_ADDR_ODSEL, 32'h4, SPP_RESP_OKAY);
      chk("pin_oe", {16'h0, pin_oe}, 32'h0000000e);
      chk("pin_out", {16'h0, pin_out & 16'h000e}, 32'h0);
      axi_wr(SPP_ADDR_LATCH, 32'h4, SPP_RESP_OKAY);
      chk("pin_oe", {16'h0, pin_oe}, 32'h0000000a);
      axi_wr(SPP_ADDR_PERI_EN, 32'h8, SPP_RESP_OKAY);
      chk("idle peri", {30'h0, pin_oe[3], pin_out[3]}, 32'h2);
      peri_oe <= 16'h0008;
      peri_out <= 16'h0008;
      repeat (2) @(posedge aclk);
      chk("peri owns", {30'h0, pin_oe[3], pin_out[3]}, 32'h3);
      repeat (4) @(posedge aclk);
      axi_rd(SPP_ADDR_LEVEL, 32'h25a9, SPP_RESP_OKAY, "level");
      chk("peri_in", {16'h0, peri_in & 16'h0008}, 32'h8);
      axi_wr(SPP_ADDR_IN_ONLY, 32'h8, SPP_RESP_OKAY);
      chk("in only", {30'h0, pin_oe[3], pin_out[3]}, 32'h2);
      axi_wr(SPP_ADDR_DIR, 32'h0, SPP_RESP_OKAY);
      chk("pin_oe", {16'h0, pin_oe}, 32'h00007ffb);
      axi_rd(8'h1c, 32'h0, SPP_RESP_SLVERR, "unmapped");
      axi_wr(8'h20, 32'h1, SPP_RESP_SLVERR);
      axi_rd(SPP_ADDR_DIR, 32'h0, SPP_RESP_OKAY, "dir");
      do_reset();
      chk("pin_oe", {16'h0, pin_oe}, 32'h0);
      axi_rd(SPP_ADDR_DIR, PRES, SPP_RESP_OKAY, "dir");
      tally_and_finish();
   end
endmodule

bind spp_port spp_port_assertions #(.WIDTH(WIDTH), .PRESENT(PRESENT))
   u_spp_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .peri_oe, .peri_in, .pin_in, .pin_oe);
